// ==== hw/dskc_core.sv ====
// Command interpreter for initialize, status transfer and track format
`timescale 1ns/1ps
// What this block and its host do
// RL1: Initialize stores fetched record per device and unit
// RL2: Tape record bit zero marks unit usable
// RL3: Disk initialize recalibrates heads to track zero
// RL4: Hard unit zero test wipes all stored settings
// RL5: Host reinitializes after power loss or reset
// RL6: Host initializes every unit, even absent ones
// RL7: Zero cylinder count takes drive out of service
// RL8: Surface count from byte 2 hard, 3 flexible
// RL9: Sectors per track taken from byte 4
// RL10: Sector size from bytes 5, 6, high 6
// RL11: Host gives spare cylinder count in byte 7
// RL12: Default 5.25-inch timing 22 ms step, 36 ms load
// RL13: Default 8-inch timing 11 ms step, 60 ms load
// RL14: Status command writes twelve bytes at pointer
// RL15: Modifier bit 6 picks long or short status
// RL16: Long status read also overwrites short status
// RL17: Format writes one track from stored settings
// RL18: Format byte 0 selects one of three types
// RL19: Data tracks fill sectors with four pattern bytes
// RL20: Defective track repeats pointer bytes 1 to 4
// RL21: Byte 5 sets interleave, one means sequential
// RL22: 5.25-inch 512-byte sectors accept 8 or 9
// RL23: Device codes 0 hard, 1, 3 flexible, 4 tape
// RL24: Host starts each command with a start write
// RL25: Interleave steps round track skipping used slots
// RL26: Unknown format type reported as status error
module dskc_core #(
   parameter int unsigned LOAD5_CYC = dskc_pkg::LOAD5_CYC,
   parameter int unsigned LOAD8_CYC = dskc_pkg::LOAD8_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [23:0] mem_addr,
   output logic      [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack,
   output logic             recal_req,
   output logic      [1:0]  recal_unit,
   output logic             recal_flex,
   output logic      [7:0]  step_ms,
   input  wire logic        recal_ack,
   output logic             trk_valid,
   input  wire logic        trk_ready,
   output logic             trk_hdr,
   output logic      [7:0]  trk_data,
   output logic      [7:0]  trk_sector,
   output logic      [1:0]  trk_kind,
   output logic      [15:0] trk_cyl,
   output logic      [7:0]  trk_head,
   output logic             cmd_busy
);
   typedef struct packed {
      dskc_pkg::dskc_state_t      state;
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
      logic [15:0]                dev;
      logic [1:0]                 unit;
      logic [7:0]                 func;
      logic [15:0]                modf;
      logic [15:0]                cyl;
      logic [7:0]                 head;
      logic [7:0]                 soff;
      logic [23:0]                bptr;
      logic                       busy;
      logic                       done;
      logic [7:0]                 err;
      logic                       mem_req;
      logic                       mem_we;
      logic [23:0]                mem_addr;
      logic [7:0]                 mem_wdata;
      logic [7:0]                 cnt;
      logic [7:0]                 len;
      logic [7:0][7:0]            pbuf;
      dskc_pkg::dskc_geo_t [7:0]  geo;
      logic [7:0]                 gval;
      logic [3:0]                 tape_ok;
      logic [11:0][7:0]           stb;
      logic [11:0][7:0]           ltb;
      logic                       recal_req;
      logic [1:0]                 recal_unit;
      logic                       recal_flex;
      logic [7:0]                 step_ms;
      logic [31:0]                wait_cnt;
      logic [31:0]                occ;
      logic [31:0][7:0]           smap;
      logic [4:0]                 pos;
      logic [7:0]                 num;
      logic [7:0]                 stp;
      logic                       trk_valid;
      logic                       trk_hdr;
      logic [7:0]                 trk_data;
      logic [7:0]                 trk_sector;
      logic [15:0]                bcnt;
   } dskc_regs_t;

   dskc_regs_t s;
   dskc_regs_t next_s;

   logic                 acc;
   logic                 go;
   logic                 is_hard;
   logic                 is_flex;
   logic                 is_tape;
   logic [2:0]           idx;
   dskc_pkg::dskc_geo_t  g;
   logic [7:0]           ilv;
   logic [4:0]           pos_inc;
   logic [15:0]          nb;

   assign acc = psel & penable & s.pready;
   assign go = acc & pwrite & (paddr == dskc_pkg::OFF_GO) & ~s.busy;
   assign is_hard = s.dev == dskc_pkg::DEV_HARD;
   assign is_flex = (s.dev == dskc_pkg::DEV_FLEX8) | (s.dev == dskc_pkg::DEV_FLEX5); // [RL23]
   assign is_tape = s.dev == dskc_pkg::DEV_TAPE;
   assign idx = {is_flex, s.unit};
   assign g = s.geo[idx];
   assign ilv = (s.pbuf[dskc_pkg::B_ILV] == 8'h00) ? 8'h01 : s.pbuf[dskc_pkg::B_ILV];
   assign pos_inc = ({3'h0, s.pos} + 8'h01 == g.spt) ? 5'h00 : s.pos + 5'h01;
   assign nb = s.bcnt + 16'h0001;

   always_comb begin
      next_s = s;
      // Register bus: answer one cycle after setup
      next_s.pready = psel & ~penable & ~s.pready;
      if (psel & ~penable & ~s.pready) begin
         next_s.pslverr = 1'b0;
         unique case (paddr)
            dskc_pkg::OFF_DEVICE: next_s.prdata = {16'h0000, s.dev};
            dskc_pkg::OFF_UNIT:   next_s.prdata = {30'h0, s.unit};
            dskc_pkg::OFF_FUNC:   next_s.prdata = {24'h0, s.func};
            dskc_pkg::OFF_MODF:   next_s.prdata = {16'h0000, s.modf};
            dskc_pkg::OFF_CYL:    next_s.prdata = {16'h0000, s.cyl};
            dskc_pkg::OFF_HEAD:   next_s.prdata = {16'h0000, s.soff, s.head};
            dskc_pkg::OFF_BPTR:   next_s.prdata = {8'h00, s.bptr};
            dskc_pkg::OFF_GO:     next_s.prdata = 32'h0;
            dskc_pkg::OFF_STATUS:
               next_s.prdata = {16'h0000, s.err, 5'h0, s.err != 8'h00, s.done, s.busy};
            default: begin
               next_s.prdata = 32'h0;
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      if (acc & pwrite & ~s.busy) begin
         unique case (paddr)
            dskc_pkg::OFF_DEVICE: next_s.dev = pwdata[15:0];
            dskc_pkg::OFF_UNIT:   next_s.unit = pwdata[1:0];
            dskc_pkg::OFF_FUNC:   next_s.func = pwdata[7:0];
            dskc_pkg::OFF_MODF:   next_s.modf = pwdata[15:0];
            dskc_pkg::OFF_CYL:    next_s.cyl = pwdata[15:0];
            dskc_pkg::OFF_HEAD:   {next_s.soff, next_s.head} = pwdata[15:0];
            dskc_pkg::OFF_BPTR:   next_s.bptr = pwdata[23:0];
            default: ;
         endcase
      end
      unique case (s.state)
         dskc_pkg::ST_IDLE: begin
            if (go) begin
               next_s.busy = 1'b1;
               next_s.done = 1'b0;
               next_s.err = dskc_pkg::ERR_NONE;
               next_s.cnt = 8'h00;
               next_s.state = dskc_pkg::ST_DONE;
               if (s.func == dskc_pkg::FN_STAT) begin
                  next_s.len = dskc_pkg::LEN_STAT;
                  next_s.state = dskc_pkg::ST_WR;
                  if (s.modf[dskc_pkg::MOD_LONG])
                     next_s.stb = s.ltb; // [RL15] [RL16]
               end else begin
                  next_s.stb = '0;
                  if (~(is_hard | is_flex | is_tape) ||
                      (s.func == dskc_pkg::FN_FMT && is_tape))
                     next_s.err = dskc_pkg::ERR_DEV;
                  else if (s.func == dskc_pkg::FN_INIT) begin
                     next_s.len = is_tape ? dskc_pkg::LEN_TAPE : dskc_pkg::LEN_DISK;
                     next_s.state = dskc_pkg::ST_RD; // [RL1]
                  end else if (s.func == dskc_pkg::FN_FMT) begin
                     if (~s.gval[idx])
                        next_s.err = dskc_pkg::ERR_OFF; // [RL7]
                     else begin
                        next_s.len = dskc_pkg::LEN_FMT;
                        next_s.state = dskc_pkg::ST_RD;
                     end
                  end else
                     next_s.err = dskc_pkg::ERR_FUNC;
               end
            end
         end
         dskc_pkg::ST_RD: begin
            next_s.mem_we = 1'b0;
            next_s.mem_addr = s.bptr + {16'h0000, s.cnt}; // [RL1]
            if (s.mem_req & mem_ack) begin
               next_s.mem_req = 1'b0;
               next_s.pbuf[s.cnt[2:0]] = mem_rdata;
               next_s.cnt = s.cnt + 8'h01;
               if (s.cnt + 8'h01 == s.len)
                  next_s.state = dskc_pkg::ST_APPLY;
            end else
               next_s.mem_req = 1'b1;
         end
         dskc_pkg::ST_APPLY: begin
            next_s.state = dskc_pkg::ST_DONE;
            if (s.func == dskc_pkg::FN_INIT) begin
               if (is_tape)
                  next_s.tape_ok[s.unit] = s.pbuf[0][0]; // [RL2]
               else begin
                  if (is_hard && s.unit == 2'b00 && ~s.modf[dskc_pkg::MOD_NOTEST]) begin
                     next_s.gval = '0; // [RL4]
                     next_s.tape_ok = '0;
                     next_s.geo = '0;
                  end
                  next_s.geo[idx].cyl = {s.pbuf[dskc_pkg::B_CYL_HI], s.pbuf[dskc_pkg::B_CYL_LO]};
                  next_s.geo[idx].heads = is_hard ? s.pbuf[dskc_pkg::B_HD_HARD]
                                                  : s.pbuf[dskc_pkg::B_HD_FLEX]; // [RL8]
                  next_s.geo[idx].spt = s.pbuf[dskc_pkg::B_SPT]; // [RL9]
                  next_s.geo[idx].sector_byte_size = {s.pbuf[dskc_pkg::B_BPS_HI],
                                         s.pbuf[dskc_pkg::B_BPS_LO]}; // [RL10]
                  next_s.geo[idx].spare = s.pbuf[dskc_pkg::B_SPARE];
                  next_s.geo[idx].dvar = s.pbuf[dskc_pkg::B_SPARE];
                  next_s.geo[idx].f5 = s.dev == dskc_pkg::DEV_FLEX5;
                  next_s.gval[idx] = {s.pbuf[dskc_pkg::B_CYL_HI],
                                      s.pbuf[dskc_pkg::B_CYL_LO]} != 16'h0000; // [RL7]
                  next_s.recal_req = 1'b1; // [RL3]
                  next_s.recal_unit = s.unit;
                  next_s.recal_flex = is_flex;
                  next_s.step_ms = 8'h00;
                  if (is_flex && s.pbuf[dskc_pkg::B_SPARE][7:1] == 7'h00)
                     next_s.step_ms = (s.dev == dskc_pkg::DEV_FLEX5)
                                    ? 8'(dskc_pkg::STEP5_MS)
                                    : 8'(dskc_pkg::STEP8_MS); // [RL12] [RL13]
                  next_s.state = dskc_pkg::ST_RECAL;
               end
            end else begin
               if (s.pbuf[dskc_pkg::B_TYPE] > dskc_pkg::FT_LAST)
                  next_s.err = dskc_pkg::ERR_TYPE; // [RL18] [RL26]
               else if (g.spt == 8'h00 || g.spt > dskc_pkg::MAX_SPT || g.sector_byte_size == 16'h0000 ||
                        (g.f5 && g.sector_byte_size == dskc_pkg::BPS_512 &&
                         g.spt != dskc_pkg::SPT_8 && g.spt != dskc_pkg::SPT_9))
                  next_s.err = dskc_pkg::ERR_SPT; // [RL22]
               else begin
                  next_s.occ = '0;
                  next_s.pos = 5'h00;
                  next_s.num = 8'h00;
                  next_s.stp = 8'h00;
                  next_s.state = dskc_pkg::ST_MAP;
               end
            end
         end
         dskc_pkg::ST_RECAL: begin
            if (recal_ack) begin
               next_s.recal_req = 1'b0;
               next_s.state = dskc_pkg::ST_DONE;
               if (s.recal_flex && g.dvar[7:1] == 7'h00) begin
                  next_s.wait_cnt = g.f5 ? LOAD5_CYC - 1 : LOAD8_CYC - 1; // [RL12] [RL13]
                  next_s.state = dskc_pkg::ST_LOAD;
               end
            end
         end
         dskc_pkg::ST_LOAD: begin
            if (s.wait_cnt == 32'h0)
               next_s.state = dskc_pkg::ST_DONE;
            else
               next_s.wait_cnt = s.wait_cnt - 32'h1;
         end
         dskc_pkg::ST_WR: begin
            next_s.mem_we = 1'b1;
            next_s.mem_addr = s.bptr + {16'h0000, s.cnt}; // [RL14]
            next_s.mem_wdata = next_s.stb[s.cnt[3:0]];
            if (s.mem_req & mem_ack) begin
               next_s.mem_req = 1'b0;
               next_s.cnt = s.cnt + 8'h01;
               if (s.cnt + 8'h01 == s.len)
                  next_s.state = dskc_pkg::ST_DONE;
            end else
               next_s.mem_req = 1'b1;
         end
         dskc_pkg::ST_MAP: begin
            if (s.num == g.spt) begin
               next_s.cnt = 8'h00;
               next_s.trk_valid = 1'b1;
               next_s.trk_hdr = 1'b1;
               next_s.trk_sector = s.smap[0];
               next_s.state = dskc_pkg::ST_HDR;
            end else if (s.stp != 8'h00) begin
               next_s.pos = pos_inc; // [RL21]
               next_s.stp = s.stp - 8'h01;
            end else if (s.occ[s.pos])
               next_s.pos = pos_inc; // [RL25]
            else begin
               next_s.smap[s.pos] = s.soff + s.num;
               next_s.occ[s.pos] = 1'b1; // [RL25]
               next_s.num = s.num + 8'h01;
               next_s.stp = ilv; // [RL21]
            end
         end
         dskc_pkg::ST_HDR: begin
            if (trk_ready) begin
               next_s.trk_hdr = 1'b0; // [RL17]
               next_s.trk_data = s.pbuf[dskc_pkg::B_PAT];
               next_s.bcnt = 16'h0000;
               next_s.state = dskc_pkg::ST_FILL;
            end
         end
         dskc_pkg::ST_FILL: begin
            if (trk_ready) begin
               if (nb == g.sector_byte_size) begin
                  if (s.cnt + 8'h01 == g.spt) begin
                     next_s.trk_valid = 1'b0; // [RL17]
                     next_s.state = dskc_pkg::ST_DONE;
                  end else begin
                     next_s.cnt = s.cnt + 8'h01;
                     next_s.trk_hdr = 1'b1;
                     next_s.trk_sector = s.smap[5'(s.cnt + 8'h01)];
                     next_s.state = dskc_pkg::ST_HDR;
                  end
               end else begin
                  next_s.bcnt = nb;
                  next_s.trk_data = s.pbuf[3'(nb[1:0]) + 3'h1]; // [RL19] [RL20]
               end
            end
         end
         dskc_pkg::ST_DONE: begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.mem_req = 1'b0;
            if (s.err != dskc_pkg::ERR_NONE)
               next_s.stb[0] = s.err; // [RL26]
            next_s.state = dskc_pkg::ST_IDLE;
         end
         default: next_s.state = dskc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s <= '0;
      else if (ce)
         s <= next_s;
   end

   assign prdata     = s.prdata;
   assign pready     = s.pready;
   assign pslverr    = s.pslverr;
   assign mem_req    = s.mem_req;
   assign mem_we     = s.mem_we;
   assign mem_addr   = s.mem_addr;
   assign mem_wdata  = s.mem_wdata;
   assign recal_req  = s.recal_req;
   assign recal_unit = s.recal_unit;
   assign recal_flex = s.recal_flex;
   assign step_ms    = s.step_ms;
   assign trk_valid  = s.trk_valid;
   assign trk_hdr    = s.trk_hdr;
   assign trk_data   = s.trk_data;
   assign trk_sector = s.trk_sector;
   assign trk_kind   = s.pbuf[dskc_pkg::B_TYPE][1:0];
   assign trk_cyl    = s.cyl;
   assign trk_head   = s.head;
   assign cmd_busy   = s.busy;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic init_disk;
   assign init_disk = s.state == dskc_pkg::ST_APPLY && s.func == dskc_pkg::FN_INIT && !is_tape;

   init_store_a: assert property (init_disk && ce |=> // [RL1] [RL9]
      s.geo[$past(idx)].spt == $past(s.pbuf[dskc_pkg::B_SPT]))
      else $error("sector count not stored");
   tape_flag_a: assert property (s.state == dskc_pkg::ST_APPLY && is_tape && ce && // [RL2]
      s.func == dskc_pkg::FN_INIT |=> s.tape_ok[$past(s.unit)] == $past(s.pbuf[0][0]))
      else $error("tape usable flag wrong");
   recal_a: assert property (init_disk && ce |=> recal_req && recal_unit == $past(s.unit)) // [RL3]
      else $error("no recalibrate on init");
   memtest_a: assert property (init_disk && ce && is_hard && s.unit == 2'b00 && // [RL4]
      !s.modf[dskc_pkg::MOD_NOTEST] |=> s.gval[7:1] == 7'h00 && s.tape_ok == 4'h0)
      else $error("memory test kept settings");
   offline_a: assert property (go && ce && s.func == dskc_pkg::FN_FMT && !is_tape && // [RL7]
      (is_hard || is_flex) && !s.gval[idx] |=> ##1 s.done && s.err == dskc_pkg::ERR_OFF)
      else $error("offline drive formatted");
   heads_a: assert property (init_disk && ce && is_flex |=> // [RL8]
      s.geo[$past(idx)].heads == $past(s.pbuf[dskc_pkg::B_HD_FLEX]))
      else $error("flexible head count wrong");
   bps_a: assert property (init_disk && ce |=> s.geo[$past(idx)].sector_byte_size == // [RL10]
      {$past(s.pbuf[dskc_pkg::B_BPS_HI]), $past(s.pbuf[dskc_pkg::B_BPS_LO])})
      else $error("sector size wrong");
   stat_addr_a: assert property (s.state == dskc_pkg::ST_WR && mem_req |-> // [RL14]
      mem_we && mem_addr == s.bptr + {16'h0000, s.cnt} && s.cnt < dskc_pkg::LEN_STAT)
      else $error("status write out of range");
   long_copy_a: assert property (go && ce && s.func == dskc_pkg::FN_STAT && // [RL15] [RL16]
      s.modf[dskc_pkg::MOD_LONG] |=> s.stb == $past(s.ltb))
      else $error("long status not copied");
   fill_a: assert property (trk_valid && !trk_hdr && s.state == dskc_pkg::ST_FILL |-> // [RL19]
      trk_data == s.pbuf[3'(s.bcnt[1:0]) + 3'h1])
      else $error("fill pattern wrong");
   bad_type_a: assert property (s.state == dskc_pkg::ST_APPLY && ce && // [RL26]
      s.func == dskc_pkg::FN_FMT && s.pbuf[0] > dskc_pkg::FT_LAST |=> ##1 s.stb[0] == dskc_pkg::ERR_TYPE)
      else $error("bad format type not reported");
   fmt_c: cover property (s.state == dskc_pkg::ST_FILL ##1 s.state == dskc_pkg::ST_DONE);
   init_c: cover property (s.state == dskc_pkg::ST_RECAL && recal_ack);
   stat_c: cover property (s.state == dskc_pkg::ST_WR ##1 s.state == dskc_pkg::ST_DONE);
endmodule

// ==== hw/dskc_pkg.sv ====
// Constants and types for the disk command block
package dskc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_DEVICE = 8'h00;
   localparam logic [7:0] OFF_UNIT   = 8'h04;
   localparam logic [7:0] OFF_FUNC   = 8'h08;
   localparam logic [7:0] OFF_MODF   = 8'h0c;
   localparam logic [7:0] OFF_CYL    = 8'h10;
   localparam logic [7:0] OFF_HEAD   = 8'h14;
   localparam logic [7:0] OFF_BPTR   = 8'h18;
   localparam logic [7:0] OFF_GO     = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   // Device codes
   localparam logic [15:0] DEV_HARD  = 16'h0000;
   localparam logic [15:0] DEV_FLEX8 = 16'h0001;
   localparam logic [15:0] DEV_FLEX5 = 16'h0003;
   localparam logic [15:0] DEV_TAPE  = 16'h0004;
   // Function codes
   localparam logic [7:0] FN_INIT = 8'h00;
   localparam logic [7:0] FN_STAT = 8'h01;
   localparam logic [7:0] FN_FMT  = 8'h02;
   // Modifier bits
   localparam int MOD_NOTEST = 0;
   localparam int MOD_LONG   = 6;
   // Record sizes and byte positions
   localparam logic [7:0] LEN_DISK = 8'h08;
   localparam logic [7:0] LEN_TAPE = 8'h01;
   localparam logic [7:0] LEN_FMT  = 8'h06;
   localparam logic [7:0] LEN_STAT = 8'h0c;
   localparam int B_CYL_LO = 0;
   localparam int B_CYL_HI = 1;
   localparam int B_HD_HARD = 2;
   localparam int B_HD_FLEX = 3;
   localparam int B_SPT    = 4;
   localparam int B_BPS_LO = 5;
   localparam int B_BPS_HI = 6;
   localparam int B_SPARE  = 7;
   localparam int B_TYPE   = 0;
   localparam int B_PAT    = 1;
   localparam int B_ILV    = 5;
   // Track types and sector limits
   localparam logic [7:0]  FT_LAST  = 8'h02;
   localparam logic [7:0]  MAX_SPT  = 8'h20;
   localparam logic [15:0] BPS_512  = 16'h0200;
   localparam logic [7:0]  SPT_8    = 8'h08;
   localparam logic [7:0]  SPT_9    = 8'h09;
   // Error codes placed in short-term status byte 0
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_DEV  = 8'h02;
   localparam logic [7:0] ERR_TYPE = 8'h03;
   localparam logic [7:0] ERR_OFF  = 8'h04;
   localparam logic [7:0] ERR_SPT  = 8'h05;
   // Flexible drive timing
   localparam int CLK_MHZ  = 200;
   localparam int STEP5_MS = 22;
   localparam int LOAD5_MS = 36;
   localparam int STEP8_MS = 11;
   localparam int LOAD8_MS = 60;
   localparam int LOAD5_CYC = LOAD5_MS * CLK_MHZ * 1000;
   localparam int LOAD8_CYC = LOAD8_MS * CLK_MHZ * 1000;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_RD    = 4'b0001,
      ST_APPLY = 4'b0011,
      ST_RECAL = 4'b0010,
      ST_LOAD  = 4'b0110,
      ST_WR    = 4'b0111,
      ST_MAP   = 4'b0101,
      ST_HDR   = 4'b0100,
      ST_FILL  = 4'b1100,
      ST_DONE  = 4'b1101
   } dskc_state_t;
   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0]  heads;
      logic [7:0]  spt;
      logic [15:0] sector_byte_size;
      logic [7:0]  spare;
      logic [7:0]  dvar;
      logic        f5;
   } dskc_geo_t;
endpackage

// ==== test/dskc_host_mem.sv ====
// Host memory and drive-side partner model
`timescale 1ns/1ps
module dskc_host_mem (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata,
   output logic             mem_ack,
   input  wire logic        recal_req,
   output logic             recal_ack,
   input  wire logic        trk_valid,
   output logic             trk_ready
);
   logic [7:0] mem [0:255];
   logic [1:0] wt;
   logic       go;
   assign go = mem_req && !mem_ack && (!slow || wt == 2'h3);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         wt <= 2'h0;
         recal_ack <= 1'b0;
         trk_ready <= 1'b0;
         mem_rdata <= 8'h5a;
      end else begin
         wt <= (mem_req && !mem_ack) ? wt + 2'h1 : 2'h0;
         mem_ack <= go;
         mem_rdata <= go ? mem[mem_addr[7:0]] : ~mem_rdata;
         if (go && mem_we)
            mem[mem_addr[7:0]] <= mem_wdata;
         recal_ack <= recal_req && !recal_ack;
         trk_ready <= trk_valid && (!slow || !trk_ready);
      end
   end
endmodule

// ==== test/dskc_core_tb_top.sv ====
// Testbench for the disk command block
`timescale 1ns/1ps
module dskc_core_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, er;
   logic        mem_req, mem_we, mem_ack, recal_req, recal_flex, recal_ack;
   logic        trk_valid, trk_ready, trk_hdr, cmd_busy;
   logic [1:0]  recal_unit, trk_kind;
   logic [7:0]  paddr, mem_wdata, mem_rdata, step_ms, trk_data, trk_sector, trk_head, es;
   logic [15:0] trk_cyl;
   logic [23:0] mem_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  sec [0:15];
   logic [7:0]  pat [0:3];
   int          fails, samples_checked, hdrs, derrs, k, recals;
   dskc_core #(.LOAD5_CYC(20), .LOAD8_CYC(30)) u_dskc_core (.pclk, .presetn, .ce(1'b1),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req,
      .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .recal_req, .recal_unit,
      .recal_flex, .step_ms, .recal_ack, .trk_valid, .trk_ready, .trk_hdr, .trk_data,
      .trk_sector, .trk_kind, .trk_cyl, .trk_head, .cmd_busy);
   dskc_host_mem u_dskc_host_mem (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .recal_req, .recal_ack, .trk_valid, .trk_ready);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   always @(posedge pclk) begin
      if (trk_valid && trk_ready && trk_hdr) begin
         sec[hdrs[3:0]] <= trk_sector;
         derrs <= derrs + int'({trk_cyl, trk_head, trk_kind} !== {16'h5, 8'h1, 2'h0});
         hdrs <= hdrs + 1;
         k <= 0;
      end else if (trk_valid && trk_ready) begin
         derrs <= derrs + int'(trk_data !== pat[k[1:0]]);
         k <= k + 1;
      end
      if (recal_req && recal_ack && recal_flex) begin
         recals++;
         chk({24'h0, step_ms}, {24'h0, es});
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(n, 0);
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task cmd(input logic [15:0] dv, input logic [1:0] u, input logic [7:0] f,
      input logic [15:0] m, input logic [7:0] p, input logic [7:0] ec);
      int n;
      apb(1'b1, dskc_pkg::OFF_DEVICE, {16'h0, dv});
      apb(1'b1, dskc_pkg::OFF_UNIT, {30'h0, u});
      apb(1'b1, dskc_pkg::OFF_FUNC, {24'h0, f});
      apb(1'b1, dskc_pkg::OFF_MODF, {16'h0, m});
      apb(1'b1, dskc_pkg::OFF_CYL, 32'h5);
      apb(1'b1, dskc_pkg::OFF_HEAD, 32'h0101);
      apb(1'b1, dskc_pkg::OFF_BPTR, {24'h0, p});
      apb(1'b1, dskc_pkg::OFF_GO, 32'h1);
      n = 0;
      do begin
         apb(1'b0, dskc_pkg::OFF_STATUS, 32'h0);
         n++;
      end while (rd[1:0] !== 2'b10 && n < 9000);
      if (n >= 9000) begin
         chk(n, 0);
         close_out();
      end
      if (ec !== 8'hff)
         chk({24'h0, rd[15:8]}, {24'h0, ec});
      $display("test done, function %h code %h", f, rd[15:8]);
   endtask
   task ld(input logic [7:0] a, input logic [63:0] v);
      for (int i = 0; i < 8; i++)
         u_dskc_host_mem.mem[a + 8'(i)] = v[8 * i +: 8];
   endtask
   initial begin
      {presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
      {fails, samples_checked, hdrs, derrs, k, recals} = '0;
      es = 8'h16;
      pat = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
      for (int i = 0; i < 256; i++)
         u_dskc_host_mem.mem[i] = 8'hff;
      ld(8'h00, 64'h00_02_00_09_02_00_00_28);
      ld(8'h10, 64'h00_00_02_3c_c3_5a_a5_00);
      ld(8'h20, 64'h00_00_02_3c_c3_5a_a5_03);
      ld(8'h30, 64'h00_02_00_09_00_02_00_00);
      ld(8'h60, 64'h1);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, er}, 32'h1);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_INIT, 16'h0, 8'h00, 8'h0);
      chk(recals, 1);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_FMT, 16'h0, 8'h10, 8'h0);
      chk(hdrs, 9);
      chk({24'h0, sec[1]}, 32'h6);
      chk(derrs, 0);
      slow <= 1'b1;
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_FMT, 16'h0, 8'h20, 8'h3);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_STAT, 16'h0, 8'h40, 8'hff);
      chk({24'h0, u_dskc_host_mem.mem[8'h40]}, 32'h3);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_STAT, 16'h40, 8'h50, 8'hff);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_STAT, 16'h0, 8'h40, 8'hff);
      chk({24'h0, u_dskc_host_mem.mem[8'h40]}, 32'h0);
      chk({24'h0, u_dskc_host_mem.mem[8'h5b]}, 32'h0);
      chk({24'h0, u_dskc_host_mem.mem[8'h5c]}, 32'hff);
      cmd(dskc_pkg::DEV_HARD, 2'h0, dskc_pkg::FN_INIT, 16'h0, 8'h30, 8'h0);
      cmd(dskc_pkg::DEV_FLEX5, 2'h0, dskc_pkg::FN_FMT, 16'h0, 8'h10, 8'h4);
      cmd(dskc_pkg::DEV_HARD, 2'h0, dskc_pkg::FN_FMT, 16'h0, 8'h10, 8'h4);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmd(dskc_pkg::DEV_TAPE, 2'h1, dskc_pkg::FN_INIT, 16'h0, 8'h60, 8'h0);
      cmd(dskc_pkg::DEV_TAPE, 2'h1, dskc_pkg::FN_FMT, 16'h0, 8'h10, 8'h2);
      es = 8'h0b;
      cmd(dskc_pkg::DEV_FLEX8, 2'h2, dskc_pkg::FN_INIT, 16'h0, 8'h00, 8'h0);
      close_out();
   end
endmodule
